// File: hw/eight_input_mux_register.sv
`include "mux_reg_defines.svh"

module eight_input_mux_register
    import mux_reg_pkg::*;
(
    input  wire logic                       i_core_clk,
    input  wire logic                       i_resetn,
    input  wire mux_pins_t                  i_pins,
    output mux_out_t                        o_out,
    input  wire logic [`MUX_REG_ADDR_W-1:0] i_avs_address,
    input  wire logic                       i_avs_read,
    input  wire logic                       i_avs_write,
    input  wire logic [31:0]                i_avs_writedata,
    output logic      [31:0]                o_avs_readdata,
    output logic                            o_avs_waitrequest
);

    localparam mux_pins_t PIN_RST = '{
        data_in:             `MUX_REG_DATA_RST,
        select_bit_high:     1'b0,
        select_bit_mid:      1'b0,
        select_bit_low:      1'b0,
        select_latch_open_n: 1'b1,
        drive_enable_a_n:    1'b1,
        drive_enable_b_n:    1'b1,
        drive_enable_c:      1'b0,
        capture_clock:       1'b0
    };

    mux_pins_t             pins_s;
    logic                  cap_prev_r;
    logic                  cap_rise;
    logic [NUM_INPUTS-1:0] stored_r;
    logic [SEL_W-1:0]      sel_in;
    logic [SEL_W-1:0]      sel_r;
    logic                  drive_on;
    logic [31:0]           ctrl_r;
    logic                  ack_r;
    logic                  bus_req;
    logic [31:0]           status_w;
    logic                  sel_level;

    // decode and status layout assume a full binary set of sources below the select field
    if (NUM_INPUTS != (1 << SEL_W)) begin : g_bad_inputs
        $error("eight_input_mux_register needs two to the SEL_W inputs");
    end
    if (`MUX_REG_ST_DATA_LSB + NUM_INPUTS > `MUX_REG_ST_SEL_LSB) begin : g_bad_status
        $error("stored data field overlaps the select field in status");
    end

    // every pin arrives from another domain, so all of them pass two flops
    pin_sync2 #(
        .WIDTH   ($bits(mux_pins_t)),
        .RST_VAL (PIN_RST)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_async    (i_pins),
        .o_sync     (pins_s)
    );

    // capture clock is sampled as a level; it must stay under half the core rate
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            cap_prev_r <= 1'b0;
        end else begin
            cap_prev_r <= pins_s.capture_clock;
        end
    end

    assign cap_rise = pins_s.capture_clock & ~cap_prev_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            stored_r <= `MUX_REG_DATA_RST;
        end else if (cap_rise) begin
            stored_r <= pins_s.data_in;
        end
    end

    assign sel_in = {pins_s.select_bit_high, pins_s.select_bit_mid, pins_s.select_bit_low};

    // transparent latch rebuilt as a load-enabled flop to stay in one clock domain
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            sel_r <= `MUX_REG_SEL_RST;
        end else if (!pins_s.select_latch_open_n) begin
            sel_r <= sel_in;
        end
    end

    // software can park the outputs off regardless of the pin enables
    assign drive_on = ~pins_s.drive_enable_a_n & ~pins_s.drive_enable_b_n
                    & pins_s.drive_enable_c & ~ctrl_r[`MUX_REG_CTRL_BLOCK];

    // no flop between latch, enables and pins, so changes show in the same cycle
    assign sel_level   = stored_r[sel_r];
    assign o_out.y     = sel_level;
    assign o_out.y_n   = ~sel_level;
    assign o_out.y_oe  = drive_on;

    // register slave: one wait cycle, then the answer
    assign bus_req           = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~ack_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`MUX_REG_ST_DATA_LSB +: NUM_INPUTS] = stored_r;
        status_w[`MUX_REG_ST_SEL_LSB +: SEL_W]       = sel_r;
        status_w[`MUX_REG_ST_DRIVE]                  = drive_on;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                `MUX_REG_CTRL_OFS:   o_avs_readdata <= ctrl_r;
                `MUX_REG_STATUS_OFS: o_avs_readdata <= status_w;
                default:             o_avs_readdata <= `MUX_REG_UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ctrl_r <= `MUX_REG_CTRL_RST;
        end else if (i_avs_write && ack_r && i_avs_address == `MUX_REG_CTRL_OFS) begin
            ctrl_r <= {31'h0000_0000, i_avs_writedata[`MUX_REG_CTRL_BLOCK]};
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    a_capture_on_rise: assert property (cap_rise |=> stored_r == $past(pins_s.data_in))
        else $error("stored data not taken on capture edge");

    a_store_holds: assert property (!cap_rise |=> $stable(stored_r))
        else $error("stored data changed without capture edge");

    a_latch_follows: assert property (!pins_s.select_latch_open_n |=> sel_r == $past(sel_in))
        else $error("select latch did not follow while open");

    a_latch_holds: assert property (pins_s.select_latch_open_n |=> $stable(sel_r))
        else $error("select latch changed while closed");

    a_drive_gating: assert property (o_out.y_oe == (!pins_s.drive_enable_a_n
        && !pins_s.drive_enable_b_n && pins_s.drive_enable_c && !ctrl_r[0]))
        else $error("output enable does not match enables");

    a_complement_pair: assert property (o_out.y_oe |-> o_out.y_n == !o_out.y)
        else $error("inverted output not complement of true output");

    a_select_route: assert property (
        o_out.y_oe |-> o_out.y == |(stored_r & (NUM_INPUTS'(1) << sel_r)))
        else $error("output does not carry selected stored input");

    a_select_binary: assert property (
        !pins_s.select_latch_open_n |=> sel_r[SEL_W-1] == $past(pins_s.select_bit_high)
        && sel_r[1] == $past(pins_s.select_bit_mid) && sel_r[0] == $past(pins_s.select_bit_low))
        else $error("select bits not decoded high to low");

    a_enable_now: assert property (
        $rose(!pins_s.drive_enable_a_n && !pins_s.drive_enable_b_n && pins_s.drive_enable_c
        && !ctrl_r[`MUX_REG_CTRL_BLOCK]) |-> o_out.y_oe)
        else $error("enable change did not reach outputs at once");

    a_fall_no_capture: assert property (
        cap_prev_r && !pins_s.capture_clock |=> $stable(stored_r))
        else $error("stored data changed on a falling capture edge");

    a_off_floats: assert property (
        (pins_s.drive_enable_a_n || pins_s.drive_enable_b_n || !pins_s.drive_enable_c)
        |-> !o_out.y_oe)
        else $error("outputs drive although an enable is off");

    a_block_floats: assert property (ctrl_r[`MUX_REG_CTRL_BLOCK] |-> !o_out.y_oe)
        else $error("outputs drive although software blocked them");

    a_route_now: assert property (
        o_out.y_oe && $changed(sel_r) |-> o_out.y == |(stored_r & (NUM_INPUTS'(1) << sel_r)))
        else $error("select change did not reach the output at once");

    a_wait_first: assert property ($rose(bus_req) |-> o_avs_waitrequest)
        else $error("bus answered without its wait cycle");

    a_ctrl_lands: assert property (
        i_avs_write && !o_avs_waitrequest && i_avs_address == `MUX_REG_CTRL_OFS
        |=> ctrl_r == {31'h0000_0000, $past(i_avs_writedata[`MUX_REG_CTRL_BLOCK])})
        else $error("control write did not land on its answer edge");

    a_status_read: assert property (
        i_avs_read && o_avs_waitrequest && i_avs_address == `MUX_REG_STATUS_OFS
        |=> o_avs_readdata[`MUX_REG_ST_DATA_LSB +: NUM_INPUTS] == $past(stored_r)
        && o_avs_readdata[`MUX_REG_ST_SEL_LSB +: SEL_W] == $past(sel_r))
        else $error("status read does not show stored data and select");

    a_unmapped_zero: assert property (
        i_avs_read && o_avs_waitrequest && i_avs_address != `MUX_REG_CTRL_OFS
        && i_avs_address != `MUX_REG_STATUS_OFS |=> o_avs_readdata == `MUX_REG_UNMAPPED_RD)
        else $error("unmapped read did not return zero");

    a_read_stands: assert property (!i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data changed with no read pending");

    a_bus_answer: assert property (bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer not given after one wait cycle");

endmodule

// File: hw/mux_reg_defines.svh
`ifndef MUX_REG_DEFINES_SVH
`define MUX_REG_DEFINES_SVH

`define MUX_REG_ADDR_W        4
`define MUX_REG_CTRL_OFS      4'h0
`define MUX_REG_STATUS_OFS    4'h4
`define MUX_REG_CTRL_RST      32'h0000_0000
`define MUX_REG_CTRL_BLOCK    0
`define MUX_REG_ST_DATA_LSB   0
`define MUX_REG_ST_SEL_LSB    8
`define MUX_REG_ST_DRIVE      11
`define MUX_REG_UNMAPPED_RD   32'h0000_0000
`define MUX_REG_SEL_RST       3'h0
`define MUX_REG_DATA_RST      8'h00

`endif

// File: hw/mux_reg_pkg.sv
package mux_reg_pkg;

    localparam int unsigned NUM_INPUTS = 8;
    localparam int unsigned SEL_W      = 3;

    // pin group driven by the surrounding logic
    typedef struct packed {
        logic [NUM_INPUTS-1:0] data_in;
        logic                  select_bit_high;
        logic                  select_bit_mid;
        logic                  select_bit_low;
        logic                  select_latch_open_n;
        logic                  drive_enable_a_n;
        logic                  drive_enable_b_n;
        logic                  drive_enable_c;
        logic                  capture_clock;
    } mux_pins_t;

    // three-state complementary output pair
    typedef struct packed {
        logic y;
        logic y_n;
        logic y_oe;
    } mux_out_t;

endpackage

// File: hw/pin_sync2.sv
module pin_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync2 needs WIDTH of at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule

// File: testbench/pin_source.sv
module pin_source
    import mux_reg_pkg::*;
(
    input  wire logic i_core_clk,
    output mux_pins_t o_pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: latch closed, outputs off, capture clock low
    initial o_pins = {8'h00, 3'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    task automatic drive(input logic [7:0] d, input logic [2:0] s, input logic le_n,
                         input logic [2:0] en);
        @(posedge i_core_clk);
        o_pins <= {d, s, le_n, en, o_pins.capture_clock};
    endtask

    // each level held 3 core cycles so no capture edge is lost
    task automatic pulse();
        @(posedge i_core_clk);
        o_pins.capture_clock <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        o_pins.capture_clock <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
endmodule

// File: testbench/test_eight_input_mux_register.sv
module test_eight_input_mux_register
    import mux_reg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, resetn, rd, wr, waitreq;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  d;
    mux_pins_t   pins;
    mux_out_t    out;
    int          err_count, samples_checked;

    pin_source ps (.i_core_clk(clk), .o_pins(pins));

    eight_input_mux_register eight_input_mux_register_i (
        .i_core_clk(clk), .i_resetn(resetn), .i_pins(pins), .o_out(out),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a request starts one edge after the last release, so no signal is set twice at once
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dv);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= dv;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic check_out(input logic y, input logic oe);
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(32'(out.y_oe), 32'(oe));
        if (oe) check(32'({out.y, out.y_n}), 32'({y, ~y}));
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        resetn = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        bus(0, 4'h4, 0); check(q, 32'h0000_0000);
        bus(0, 4'h8, 0); check(q, 32'h0000_0000);
        bus(0, 4'h0, 0); check(q, 32'h0000_0000);
        bus(1, 4'h8, 32'h0000_0001);
        bus(0, 4'h0, 0); check(q, 32'h0000_0000);
        $display("reset test done");
        for (int s = 0; s < 8; s++) begin
            d = (s % 2) ? ~(8'h01 << s) : (8'h01 << s);
            ps.drive(d, 3'(s), 1'b0, 3'b001);
            ps.pulse();
            check_out(d[s], 1'b1);
            bus(0, 4'h4, 0); check(q, {20'h0_0000, 1'b1, 3'(s), d});
        end
        $display("select test done");
        ps.drive(8'h7F, 3'h0, 1'b1, 3'b001);
        check_out(1'b0, 1'b1);
        ps.drive(8'hFF, 3'h0, 1'b1, 3'b001);
        check_out(1'b0, 1'b1);
        ps.pulse();
        check_out(1'b1, 1'b1);
        $display("latch and capture test done");
        ps.drive(8'hFF, 3'h0, 1'b1, 3'b101); check_out(1'b1, 1'b0);
        ps.drive(8'hFF, 3'h0, 1'b1, 3'b011); check_out(1'b1, 1'b0);
        ps.drive(8'hFF, 3'h0, 1'b1, 3'b000); check_out(1'b1, 1'b0);
        ps.drive(8'hFF, 3'h0, 1'b1, 3'b001); check_out(1'b1, 1'b1);
        bus(1, 4'h0, 32'h0000_0001); check_out(1'b1, 1'b0);
        bus(0, 4'h0, 0); check(q, 32'h0000_0001);
        bus(1, 4'h0, 32'h0000_0000); check_out(1'b1, 1'b1);
        $display("enable test done");
        results();
    end
endmodule
